/* bench/dsrw_mem_model.sv */
`timescale 1ns/1ps
// Memory side of one strobe group; it drives strobe and data only during reads.
module dsrw_mem_model
(
  output logic dqs,
  output logic [7:0] dq
);
  // Released lines show the inverse of the last level, since nothing holds them here.
  initial
  begin
    dqs = 1'b1;
    dq = 8'hff;
  end

  // One read: a low preamble, one word on every strobe edge, then a low postamble that stays driven.
  task automatic burst(input logic [7:0] w[$]);
    #3;
    dqs = 1'b0;
    #125;
    foreach (w[i])
    begin
      dqs = ~dqs;
      dq = w[i];
      #62.5;
    end
    dqs = 1'b0;
    #62.5;
  endtask

  // Release once the core has closed the read, so the rising idle level is not taken as data.
  task automatic free_bus();
    #3;
    dqs = 1'b1;
    dq = ~dq;
  endtask
endmodule

/* bench/tb_ddr_strobe_read_write_ctrl.sv */
`timescale 1ns/1ps
`include "dsrw_map.svh"
// Self-checking bench for the strobe control element and its read FIFO.
module tb_ddr_strobe_read_write_ctrl;
  logic clk, rstn, read_en, ddr_mode, tdi, tci, rd_ready, sdr_drv, sdr_chk, drain;
  logic [5:0] cal;
  logic dqs_w, dqs_out, dqs_oe, dq_oe, rs_clk, ws_clk, pol, rd_valid, overrun, rs_last, ws_last;
  logic [7:0] dq_w, rd_data;
  logic [31:0] seed = 32'h1a;
  logic [31:0] r, v;
  logic [7:0] rd_q[$];
  logic oe_q[$];
  int miscompares = 0;
  int comparisons = 0;
  int n = 0;
  int rs_n = 0;
  int ws_n = 0;

  // The clock runs at 100 MHz.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  dsrw_mem_model mem (.dqs(dqs_w), .dq(dq_w));

  dsrw_strobe_ctrl #(.DQ_W(8)) dut (.clk(clk), .rstn(rstn), .dqs_in(dqs_w), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe), .dq_in(dq_w), .dq_oe(dq_oe), .read_en(read_en), .ddr_mode(ddr_mode),
    .dll_cal_code(cal), .tristate_data_in(tdi), .tristate_ctrl_in(tci),
    .read_strobe_shifted_clk(rs_clk), .write_strobe_shifted_clk(ws_clk),
    .capture_clock_polarity_sel(pol), .read_data_valid(rd_valid), .read_data(rd_data),
    .read_data_ready(rd_ready), .read_overrun(overrun));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // The core stalls at random; with drain low it stalls fully so that the FIFO fills.
  always @(posedge clk)
  begin
    r = rnd();
    rd_ready <= drain & (r[1] | r[2]);
    sdr_chk <= sdr_drv;
  end

  // Every accepted word is matched against the oldest noted word.
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
    begin
      n++;
      check("read word noted", 8'(rd_q.size() != 0), 8'h01);
      if (rd_q.size() != 0)
        check("read data", rd_data, rd_q.pop_front());
    end
    // Each strobe edge at the pin must come out once on each delayed strobe.
    if (rs_clk !== rs_last)
      rs_n++;
    if (ws_clk !== ws_last)
      ws_n++;
    rs_last = rs_clk;
    ws_last = ws_clk;
  end

  // The enable is looked at mid-cycle, one cycle after the tri-state input was taken.
  always @(negedge clk)
    if (sdr_chk === 1'b1)
      check("sdr oe", 8'(dq_oe), 8'(oe_q.pop_front()));

  // One read of nw words, nw even; only the first nk of them are expected to reach the core.
  task automatic do_read(input logic [5:0] code, input int nw, input int nk);
    logic [7:0] w[$];
    logic [31:0] x;
    cal <= code;
    rs_n = 0;
    ws_n = 0;
    for (int i = 0; i < nw; i++)
    begin
      x = rnd();
      w.push_back(x[7:0]);
      if (i < nk)
        rd_q.push_back(x[7:0]);
    end
    @(posedge clk);
    read_en <= 1'b1;
    @(posedge clk);
    mem.burst(w);
    // The last delayed edge lands within ten cycles; the read closes before the strobe is let go.
    repeat (10) @(posedge clk);
    read_en <= 1'b0;
    repeat (2) @(posedge clk);
    mem.free_bus();
    drain <= 1'b1;
    repeat (80) @(posedge clk);
    check("read drained", 8'(rd_q.size()), 8'h00);
    check("read strobe edges", 8'(rs_n), 8'(nw + 2));
    check("write strobe edges", 8'(ws_n), 8'(nw + 2));
  endtask

  // Cuts a hang short at about ten times the expected run.
  initial
  begin
    #100000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    rstn = 1'b0;
    read_en = 1'b0;
    ddr_mode = 1'b1;
    tdi = 1'b0;
    tci = 1'b0;
    cal = 6'h00;
    rd_ready = 1'b0;
    sdr_drv = 1'b0;
    sdr_chk = 1'b0;
    drain = 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    // Without a strobe rise the write-strobe register keeps its release value.
    check("ddr oe idle", 8'(dq_oe), 8'h00);
    do_read(6'h00, 6, 6);
    check("ddr oe on", 8'({dq_oe, dqs_oe}), 8'h03);
    check("polarity known", 8'(pol === 1'b0 || pol === 1'b1), 8'h01);
    tci <= 1'b1;
    repeat (10) @(posedge clk);
    check("ddr oe held", 8'(dq_oe), 8'h01);
    do_read(6'h01, 6, 6);
    check("ddr oe off", 8'(dq_oe), 8'h00);
    do_read(6'h02, 6, 6);
    check("overrun", 8'(overrun), 8'h00);
    v[0] = dqs_out;
    @(posedge clk);
    check("strobe out toggles", 8'(dqs_out ^ v[0]), 8'h01);
    $display("test ddr reads and tristate done");
    ddr_mode <= 1'b0;
    @(posedge clk);
    sdr_drv <= 1'b1;
    repeat (30)
    begin
      v = rnd();
      tdi <= v[0];
      oe_q.push_back(~v[0]);
      @(posedge clk);
    end
    sdr_drv <= 1'b0;
    repeat (3) @(posedge clk);
    check("sdr strobe oe", 8'(dqs_oe), 8'h00);
    $display("test sdr tristate done");
    // A fully stalled core keeps the output word, a full FIFO and one pending capture; later words are lost.
    drain <= 1'b0;
    n = 0;
    do_read(6'h01, 40, `DSRW_FIFO_DEPTH + 2);
    check("fifo fill", 8'(n), 8'(`DSRW_FIFO_DEPTH + 2));
    check("fifo left", 8'(rd_q.size()), 8'h00);
    check("fifo overrun", 8'(overrun), 8'h01);
    check("fifo empty", 8'(rd_valid), 8'h00);
    $display("test fifo fill and drain done");
    give_verdict();
  end
endmodule

/* rtl/dsrw_strobe_ctrl.sv */
// Behaviour
// - The memory edge has two strobe groups, each of either 14 or 12 I/O cells.
// - All groups together carry a memory data path of at most 16 bits.
// - One cell per group holds this element, which drives read strobe, write strobe, polarity and valid to the group.
// - Both shifted strobe clocks are derived from the incoming data strobe.
// - The first rising strobe edge after the preamble is detected and sets the polarity select.
// - The polarity select picks the system clock edge on which captured read data is synchronised.
// - The polarity is evaluated afresh at the start of every read.
// - The strobe delay is set by a 6-bit calibration code from the DLL.
// - Tri-state controls from the core are registered before they reach the buffers.
// - In single data rate mode the tri-state data input passes one flip-flop that drives the output enable.
// - In memory DDR mode the tri-state input passes an extra register clocked by the write strobe.
`timescale 1ns/1ps
`include "dsrw_map.svh"

// Flip-flop FIFO; back-pressure shows as in_ready low while full.
module dsrw_fifo
#(
  parameter int WIDTH = `DSRW_DQ_W,
  parameter int DEPTH = `DSRW_FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  // Refused at elaboration: the wrap bit of the pointers only works for a power-of-two depth.
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_depth_check
    $error("FIFO depth must be a power of two of at least two.");
  end

  // Full when the pointers differ only in the wrap bit.
  always_comb
  begin
    in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    out_valid = (wr_ptr != rd_ptr);
    out_data = mem[rd_ptr[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Storage has no reset; only the pointers define emptiness.
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
endmodule

// Strobe control element of one DDR memory group.
module dsrw_strobe_ctrl
  import dsrw_pkg::*;
#(
  parameter int GROUP_CELLS = `DSRW_GROUP_CELLS_LARGE,
  parameter int DQ_W = `DSRW_DQ_W,
  parameter int FIFO_DEPTH = `DSRW_FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_oe,
  input wire logic [DQ_W-1:0] dq_in,
  output logic dq_oe,
  input wire logic read_en,
  input wire logic ddr_mode,
  input wire logic [`DSRW_CAL_W-1:0] dll_cal_code,
  input wire logic tristate_data_in,
  input wire logic tristate_ctrl_in,
  output logic read_strobe_shifted_clk,
  output logic write_strobe_shifted_clk,
  output logic capture_clock_polarity_sel,
  output logic read_data_valid,
  output logic [DQ_W-1:0] read_data,
  input wire logic read_data_ready,
  output logic read_overrun
);
  localparam int TAPS = 1 << `DSRW_CAL_W;

  // Group size and total width are fixed by the edge layout.
  if (GROUP_CELLS != `DSRW_GROUP_CELLS_LARGE && GROUP_CELLS != `DSRW_GROUP_CELLS_SMALL)
  begin : g_cells_check
    $error("A strobe group holds 14 or 12 cells.");
  end
  if (DQ_W < 1 || DQ_W * `DSRW_GROUP_COUNT > `DSRW_MAX_BUS_W || DQ_W > GROUP_CELLS - 2)
  begin : g_width_check
    $error("Data width exceeds what the groups can carry.");
  end

  // Pin inputs pass two flip-flops; only the second stage is read.
  logic dqs_m;
  logic dqs_s;
  logic dqs_prev;
  logic [DQ_W-1:0] dq_m;
  logic [DQ_W-1:0] dq_s;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      // The released strobe idles high, so the chain starts there and no false edge follows reset.
      dqs_m <= 1'b1;
      dqs_s <= 1'b1;
      dqs_prev <= 1'b1;
      dq_m <= '0;
      dq_s <= '0;
    end
    else
    begin
      dqs_m <= dqs_in;
      dqs_s <= dqs_m;
      dqs_prev <= dqs_s;
      dq_m <= dq_in;
      dq_s <= dq_m;
    end
  end

  logic dqs_rise;
  assign dqs_rise = dqs_s && !dqs_prev;

  // Delay line on the strobe; the DLL code picks the tap, so the delay tracks PVT.
  logic [TAPS-1:0] taps;
  logic next_rs;
  logic next_ws;
  logic ws_prev;
  logic rs_prev;
  always_comb
  begin
    next_rs = taps[dll_cal_code];
    next_ws = taps[dll_cal_code >> 1];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      // Start at the idle strobe level; a low start would fake a write strobe rise and drive the pins.
      taps <= '1;
      read_strobe_shifted_clk <= 1'b1;
      write_strobe_shifted_clk <= 1'b1;
      rs_prev <= 1'b1;
      ws_prev <= 1'b1;
    end
    else
    begin
      taps <= {taps[TAPS-2:0], dqs_s};
      read_strobe_shifted_clk <= next_rs;
      write_strobe_shifted_clk <= next_ws;
      rs_prev <= read_strobe_shifted_clk;
      ws_prev <= write_strobe_shifted_clk;
    end
  end

  logic rs_edge;
  logic ws_rise;
  assign rs_edge = read_strobe_shifted_clk ^ rs_prev;
  assign ws_rise = write_strobe_shifted_clk && !ws_prev;

  // Read sequence: wait for the driven-low preamble, then latch polarity on the first rise.
  dsrw_rd_state_t state;
  dsrw_rd_state_t next_state;
  logic phase;
  logic next_pol;
  always_comb
  begin
    next_state = state;
    next_pol = capture_clock_polarity_sel;
    case (state)
      DSRW_RD_IDLE:
        if (read_en)
          next_state = DSRW_RD_PRE;
      DSRW_RD_PRE:
        if (!read_en)
          next_state = DSRW_RD_IDLE;
        else if (!dqs_s)
          next_state = DSRW_RD_ARM;
      DSRW_RD_ARM:
        if (!read_en)
          next_state = DSRW_RD_IDLE;
        else if (dqs_rise)
        begin
          next_pol = phase;
          next_state = DSRW_RD_BURST;
        end
      DSRW_RD_BURST:
        if (!read_en)
          next_state = DSRW_RD_IDLE;
      default:
        next_state = DSRW_RD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= DSRW_RD_IDLE;
      phase <= 1'b0;
      capture_clock_polarity_sel <= 1'b0;
    end
    else
    begin
      state <= next_state;
      phase <= !phase;
      capture_clock_polarity_sel <= next_pol;
    end
  end

  // Capture on each delayed strobe edge; hand over only on the selected system clock phase.
  logic [DQ_W-1:0] cap_word;
  logic cap_pend;
  logic [DQ_W-1:0] next_cap_word;
  logic next_cap_pend;
  logic next_overrun;
  logic push;
  logic fifo_ready;
  logic fifo_valid;
  logic [DQ_W-1:0] fifo_data;
  logic pop;
  logic strobe_take;
  always_comb
  begin
    push = cap_pend && (phase == capture_clock_polarity_sel) && fifo_ready;
    strobe_take = (state == DSRW_RD_BURST) && rs_edge;
    next_cap_word = cap_word;
    next_cap_pend = cap_pend && !push;
    next_overrun = read_overrun;
    if (state == DSRW_RD_IDLE && read_en)
      next_overrun = 1'b0;
    // A word that arrives while the last one still waits is lost and flagged.
    if (strobe_take && next_cap_pend)
      next_overrun = 1'b1;
    else if (strobe_take)
    begin
      next_cap_word = dq_s;
      next_cap_pend = 1'b1;
    end
  end

  dsrw_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(cap_word),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // Output stage keeps valid and data on flip-flops while the core stalls.
  logic next_valid;
  logic [DQ_W-1:0] next_data;
  always_comb
  begin
    pop = fifo_valid && (!read_data_valid || read_data_ready);
    next_valid = read_data_valid && !read_data_ready;
    next_data = read_data;
    if (pop)
    begin
      next_valid = 1'b1;
      next_data = fifo_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cap_word <= '0;
      cap_pend <= 1'b0;
      read_overrun <= 1'b0;
      read_data_valid <= 1'b0;
      read_data <= '0;
    end
    else
    begin
      cap_word <= next_cap_word;
      cap_pend <= next_cap_pend;
      read_overrun <= next_overrun;
      read_data_valid <= next_valid;
      read_data <= next_data;
    end
  end

  // Tri-state path; controls are high for release, enables high while driving.
  logic ts_ddr;
  logic next_ts_ddr;
  logic next_oe;
  always_comb
  begin
    next_ts_ddr = ws_rise ? tristate_ctrl_in : ts_ddr;
    next_oe = ddr_mode ? !ts_ddr : !tristate_data_in;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ts_ddr <= 1'b1;
      dq_oe <= 1'b0;
      dqs_oe <= 1'b0;
      dqs_out <= 1'b0;
    end
    else
    begin
      ts_ddr <= next_ts_ddr;
      dq_oe <= next_oe;
      dqs_oe <= next_oe && ddr_mode;
      dqs_out <= phase;
    end
  end

  sequence s_read_request;
    state == DSRW_RD_IDLE && read_en;
  endsequence

  sequence s_first_rise;
    state == DSRW_RD_ARM && read_en && dqs_rise;
  endsequence

  chk_read_start_pre: assert property (@(posedge clk) disable iff (!rstn) s_read_request |=> state == DSRW_RD_PRE)
    else $error("Read request did not enter the preamble wait.");
  chk_preamble_low_arm: assert property (@(posedge clk) disable iff (!rstn)
    (state == DSRW_RD_PRE && read_en && !dqs_s) |=> state == DSRW_RD_ARM)
    else $error("Low strobe in preamble did not arm the detector.");
  chk_polarity_latch: assert property (@(posedge clk) disable iff (!rstn)
    s_first_rise |=> (capture_clock_polarity_sel == $past(phase)) && state == DSRW_RD_BURST)
    else $error("Polarity not taken at first strobe rise.");
  // A pending word must wait out the wrong phase instead of crossing into the system clock domain.
  chk_push_on_phase: assert property (@(posedge clk) disable iff (!rstn)
    cap_pend && phase != capture_clock_polarity_sel |=> cap_pend)
    else $error("Read word synchronised on the wrong clock phase.");
  chk_strobe_tap: assert property (@(posedge clk) disable iff (!rstn)
    $stable(dll_cal_code) |=> read_strobe_shifted_clk == $past(taps[dll_cal_code]))
    else $error("Read strobe not taken from the calibrated tap.");
  chk_sdr_enable: assert property (@(posedge clk) disable iff (!rstn) !ddr_mode |=> dq_oe == !$past(tristate_data_in))
    else $error("SDR output enable does not follow one register.");
  chk_ddr_ts_hold: assert property (@(posedge clk) disable iff (!rstn) !ws_rise |=> ts_ddr == $past(ts_ddr))
    else $error("DDR tri-state register moved without a write strobe edge.");
  chk_valid_held: assert property (@(posedge clk) disable iff (!rstn)
    read_data_valid && !read_data_ready |=> read_data_valid && $stable(read_data))
    else $error("Read data dropped while the core stalled.");
endmodule

/* shared/dsrw_map.svh */
`ifndef DSRW_MAP_SVH
`define DSRW_MAP_SVH
// Allowed I/O cell counts for one strobe group.
`define DSRW_GROUP_CELLS_LARGE 14
`define DSRW_GROUP_CELLS_SMALL 12
// Number of strobe groups on the memory-capable edge.
`define DSRW_GROUP_COUNT 2
// Widest memory data path that all groups together may carry.
`define DSRW_MAX_BUS_W 16
// Default data width of one group.
`define DSRW_DQ_W 8
// Width of the delay calibration code from the DLL.
`define DSRW_CAL_W 6
// Depth of the read data FIFO in words.
`define DSRW_FIFO_DEPTH 32
`endif

/* shared/dsrw_pkg.sv */
package dsrw_pkg;
  // Read sequence states of the strobe control element.
  typedef enum logic [1:0] {
    DSRW_RD_IDLE,
    DSRW_RD_PRE,
    DSRW_RD_ARM,
    DSRW_RD_BURST
  } dsrw_rd_state_t;
endpackage
